/* src/spi_map_pkg.sv */
// constants, types and address map for the serial register bank
package spi_map_pkg;

  // ********************************************************
  // header byte layout
  // ********************************************************
  localparam logic [7:0] HDR_WRITE_SINGLE = 8'h00; // plain base address
  localparam logic [7:0] HDR_WRITE_BURST = 8'h40; // burst write offset
  localparam logic [7:0] HDR_READ_SINGLE = 8'h80; // single read offset
  localparam logic [7:0] HDR_READ_BURST = 8'hC0; // burst read offset
  localparam int HDR_RW_BIT = 7; // read when set
  localparam int HDR_BURST_BIT = 6; // burst when set
  localparam int ADDR_MSB = 5; // base address top bit

  // ********************************************************
  // address map
  // ********************************************************
  localparam logic [5:0] ADDR_PIN1_CFG = 6'h01; // aux_pin1_output_config
  localparam logic [5:0] ADDR_PIN0_CFG = 6'h02; // aux_pin0_output_config
  localparam logic [5:0] ADDR_CFG_LAST = 6'h2F; // end of config region
  localparam logic [5:0] ADDR_MULTI_FIRST = 6'h3E; // multi-byte slots start
  localparam logic [5:0] ADDR_STEP = 6'h01; // burst address step

  // ********************************************************
  // pin config fields and reset values
  // ********************************************************
  localparam int CFG_DRIVE_BIT = 7; // drive strength, pin1 register
  localparam int CFG_TEMP_BIT = 7; // temperature sensor, pin0 register
  localparam int CFG_INV_BIT = 6; // output invert
  localparam int CFG_SEL_MSB = 5; // signal select top bit
  localparam logic [7:0] PIN1_CFG_RESET = 8'h2E; // pin1 high-z
  localparam logic [7:0] PIN0_CFG_RESET = 8'h3F; // pin0 crystal/192
  localparam logic [5:0] SEL_HIGH_Z = 6'h2E; // select code for high-z
  localparam logic [5:0] SEL_XOSC_DIV = 6'h3F; // select code for divided clock
  localparam int XOSC_DIV = 192; // crystal clock divide ratio
  localparam logic [6:0] XOSC_HALF_LAST = 7'(XOSC_DIV / 2 - 1); // half period end
  localparam logic [6:0] DIV_STEP = 7'h01; // divider increment
  localparam logic [2:0] BIT_LAST = 3'h7; // last bit index in a byte
  localparam logic [2:0] BIT_STEP = 3'h1; // bit counter increment

  // ********************************************************
  // transaction phase
  // ********************************************************
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_HEADER = 2'h1,
    PH_DATA = 2'h3
  } phase_e;

endpackage : spi_map_pkg

/* src/spi_link_if.sv */
// byte-level link between the serial shifter and the register bank
`timescale 1ns/100ps
interface spi_link_if;
  logic cs_active; // chip select held low, synchronised
  logic cs_start; // one-cycle pulse at select assertion
  logic byte_done; // one-cycle pulse, rx_byte valid
  logic [7:0] rx_byte; // last byte shifted in
  logic [7:0] tx_next; // byte to shift out next

  modport engine (output cs_active, output cs_start, output byte_done, output rx_byte,
    input tx_next);
  modport bank (input cs_active, input cs_start, input byte_done, input rx_byte,
    output tx_next);
endinterface : spi_link_if

/* src/spi_byte_engine.sv */
// serial pin synchroniser and byte shifter, mode 0, msb first
`timescale 1ns/100ps
module spi_byte_engine
  import spi_map_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic spi_csn,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  spi_link_if.engine link
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic csn_s1; // first sync stage
    logic csn_s2; // second sync stage
    logic csn_q; // previous synced value
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_q;
    logic mosi_s1;
    logic mosi_s2;
    logic [2:0] bit_cnt; // bits received in this byte
    logic [7:0] rx_sr; // receive shifter
    logic [7:0] tx_sr; // transmit shifter
    logic miso; // output bit
    logic miso_oe; // output drive
    logic cs_start;
    logic byte_done;
    logic [7:0] rx_byte;
  } engine_state_s;

  localparam engine_state_s ENGINE_RESET = '{csn_s1: 1'b1, csn_s2: 1'b1, csn_q: 1'b1,
    sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_q: 1'b0, mosi_s1: 1'b0, mosi_s2: 1'b0,
    bit_cnt: 3'h0, rx_sr: 8'h00, tx_sr: 8'h00, miso: 1'b0, miso_oe: 1'b0,
    cs_start: 1'b0, byte_done: 1'b0, rx_byte: 8'h00};

  engine_state_s r; // registered state
  engine_state_s next_r; // next state

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    next_r = r;
    // two-flop synchronisers, first stage read only by second
    next_r.csn_s1 = spi_csn;
    next_r.csn_s2 = r.csn_s1;
    next_r.csn_q = r.csn_s2;
    next_r.sclk_s1 = spi_sclk;
    next_r.sclk_s2 = r.sclk_s1;
    next_r.sclk_q = r.sclk_s2;
    next_r.mosi_s1 = spi_mosi;
    next_r.mosi_s2 = r.mosi_s1;
    next_r.cs_start = 1'b0;
    next_r.byte_done = 1'b0;
    if (r.csn_s2) begin
      // deselected: release output, restart byte framing
      next_r.bit_cnt = 3'h0;
      next_r.miso_oe = 1'b0;
      next_r.miso = 1'b0;
    end else begin
      next_r.miso_oe = 1'b1;
      if (r.csn_q) begin
        // select edge: first byte out is the status byte
        next_r.cs_start = 1'b1;
        next_r.bit_cnt = 3'h0;
        next_r.tx_sr = link.tx_next;
        next_r.miso = link.tx_next[7];
      end else if (r.sclk_s2 && !r.sclk_q) begin
        // rising edge: sample input
        next_r.rx_sr = {r.rx_sr[6:0], r.mosi_s2};
        next_r.bit_cnt = r.bit_cnt + BIT_STEP;
        if (r.bit_cnt == BIT_LAST) begin
          next_r.byte_done = 1'b1;
          next_r.rx_byte = {r.rx_sr[6:0], r.mosi_s2};
        end
      end else if (!r.sclk_s2 && r.sclk_q) begin
        // falling edge: load next byte at boundary, else shift
        if (r.bit_cnt == 3'h0) begin
          next_r.tx_sr = link.tx_next;
          next_r.miso = link.tx_next[7];
        end else begin
          next_r.tx_sr = {r.tx_sr[6:0], 1'b0};
          next_r.miso = r.tx_sr[6];
        end
      end
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= ENGINE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign spi_miso = r.miso;
  assign spi_miso_oe = r.miso_oe;
  assign link.cs_active = !r.csn_s2;
  assign link.cs_start = r.cs_start;
  assign link.byte_done = r.byte_done;
  assign link.rx_byte = r.rx_byte;

endmodule : spi_byte_engine

/* src/spi_pin_config_top.sv */
// serial address decode, pin configuration registers and output pin drive
//
// Notes on behaviour
// - header adds burst/read offsets; config region burstable
// - upper writes strobe; upper burst reads give status
// - burst meaning differs above config region
// - unimplemented config registers read back zero
// - status byte returned during header and writes
// - pin1 bit7 sets drive strength, reset 0
// - bit6 inverts pin output, reset 0
// - pin1 select bits 5:0, reset high-z
// - pin0 bit7 enables temperature sensor
// - pin0 select bits 5:0, reset crystal/192
`timescale 1ns/100ps
module spi_pin_config_top
  import spi_map_pkg::*;
#(
  parameter int SIGNAL_COUNT = 64
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic spi_csn,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [7:0] chip_status_byte,
  input wire logic [SIGNAL_COUNT-1:0] internal_signals,
  output logic [5:0] status_reg_addr,
  input wire logic [7:0] status_reg_data,
  output logic strobe_valid,
  output logic [5:0] strobe_code,
  output logic multi_write,
  output logic [5:0] multi_write_addr,
  output logic [7:0] multi_write_data,
  output logic general_output_pin0,
  output logic general_output_pin0_oe,
  output logic general_output_pin1,
  output logic general_output_pin1_oe,
  output logic pin_drive_strength,
  output logic temp_sensor_enable
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    phase_e phase; // transaction phase
    logic rw; // read access
    logic burst; // burst bit of header
    logic [5:0] addr; // current base address
    logic fetch; // refresh tx byte this cycle
    logic [7:0] pin1_cfg; // aux_pin1_output_config
    logic [7:0] pin0_cfg; // aux_pin0_output_config
    logic [7:0] tx_next; // next byte for the shifter
    logic strobe; // strobe pulse
    logic [5:0] strobe_code;
    logic mwr; // multi-byte slot write pulse
    logic [7:0] mwr_data;
    logic [6:0] div_cnt; // crystal divider count
    logic xclk_div; // divided crystal clock
    logic p0; // pin levels and enables
    logic p0_oe;
    logic p1;
    logic p1_oe;
    logic drive;
    logic temp;
  } bank_state_s;

  localparam bank_state_s BANK_RESET = '{phase: PH_IDLE, rw: 1'b0, burst: 1'b0,
    addr: 6'h00, fetch: 1'b0, pin1_cfg: PIN1_CFG_RESET, pin0_cfg: PIN0_CFG_RESET,
    tx_next: 8'h00, strobe: 1'b0, strobe_code: 6'h00, mwr: 1'b0, mwr_data: 8'h00,
    div_cnt: 7'h00, xclk_div: 1'b0, p0: 1'b0, p0_oe: 1'b0, p1: 1'b0, p1_oe: 1'b0,
    drive: 1'b0, temp: 1'b0};

  bank_state_s r; // registered state
  bank_state_s next_r; // next state
  spi_link_if link (); // byte link to the shifter

  // ********************************************************
  // helpers
  // ********************************************************
  // config region holds burst-incrementing registers
  function automatic logic in_cfg(input logic [5:0] a);
    return a <= ADDR_CFG_LAST;
  endfunction : in_cfg

  // chosen signal, then inversion
  function automatic logic pin_level(input logic [7:0] cfg,
      input logic [SIGNAL_COUNT-1:0] sigs, input logic xclk);
    logic s;
    s = (cfg[CFG_SEL_MSB:0] == SEL_XOSC_DIV) ? xclk : sigs[cfg[CFG_SEL_MSB:0]];
    return s ^ cfg[CFG_INV_BIT];
  endfunction : pin_level

  // ********************************************************
  // shifter
  // ********************************************************
  spi_byte_engine u_engine (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .spi_csn(spi_csn),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .link(link.engine)
  );

  // ********************************************************
  // decode, registers and pins
  // ********************************************************
  always_comb begin
    next_r = r;
    next_r.strobe = 1'b0;
    next_r.mwr = 1'b0;
    next_r.fetch = 1'b0;
    if (link.cs_start) begin
      next_r.phase = PH_HEADER;
    end else if (!link.cs_active) begin
      next_r.phase = PH_IDLE;
    end else if (link.byte_done) begin
      case (r.phase)
        PH_HEADER: begin
          // split header into access bits and base address
          next_r.rw = link.rx_byte[HDR_RW_BIT];
          next_r.burst = link.rx_byte[HDR_BURST_BIT];
          next_r.addr = link.rx_byte[ADDR_MSB:0];
          next_r.fetch = 1'b1;
          if (!in_cfg(link.rx_byte[ADDR_MSB:0]) &&
              link.rx_byte[ADDR_MSB:0] < ADDR_MULTI_FIRST &&
              !(link.rx_byte[HDR_RW_BIT] && link.rx_byte[HDR_BURST_BIT])) begin
            // upper region write or single read is a strobe
            next_r.strobe = 1'b1;
            next_r.strobe_code = link.rx_byte[ADDR_MSB:0];
          end else begin
            next_r.phase = PH_DATA;
          end
        end
        PH_DATA: begin
          if (!r.rw && r.addr == ADDR_PIN1_CFG) begin
            next_r.pin1_cfg = link.rx_byte;
          end else if (!r.rw && r.addr == ADDR_PIN0_CFG) begin
            next_r.pin0_cfg = link.rx_byte;
          end else if (!r.rw && !in_cfg(r.addr)) begin
            // multi-byte slot, handed out byte by byte
            next_r.mwr = 1'b1;
            next_r.mwr_data = link.rx_byte;
          end
          next_r.fetch = 1'b1;
          if (r.burst && (in_cfg(r.addr) || r.addr >= ADDR_MULTI_FIRST)) begin
            // config burst steps the address, multi-byte slots stay
            if (in_cfg(r.addr)) begin
              next_r.addr = r.addr + ADDR_STEP;
            end
          end else begin
            next_r.phase = PH_HEADER;
          end
        end
        default: begin
          next_r.phase = PH_IDLE;
        end
      endcase
    end
    // byte to return next: data for reads, status otherwise
    if (r.phase != PH_DATA || !r.rw) begin
      next_r.tx_next = chip_status_byte;
    end else if (r.fetch) begin
      if (r.addr == ADDR_PIN1_CFG) begin
        next_r.tx_next = r.pin1_cfg;
      end else if (r.addr == ADDR_PIN0_CFG) begin
        next_r.tx_next = r.pin0_cfg;
      end else if (in_cfg(r.addr)) begin
        next_r.tx_next = 8'h00;
      end else begin
        next_r.tx_next = status_reg_data;
      end
    end
    // crystal clock divider
    if (r.div_cnt == XOSC_HALF_LAST) begin
      next_r.div_cnt = 7'h00;
      next_r.xclk_div = !r.xclk_div;
    end else begin
      next_r.div_cnt = r.div_cnt + DIV_STEP;
    end
    // pin drive from the configuration
    next_r.p1 = pin_level(r.pin1_cfg, internal_signals, r.xclk_div);
    next_r.p1_oe = r.pin1_cfg[CFG_SEL_MSB:0] != SEL_HIGH_Z;
    next_r.p0 = pin_level(r.pin0_cfg, internal_signals, r.xclk_div);
    next_r.p0_oe = r.pin0_cfg[CFG_SEL_MSB:0] != SEL_HIGH_Z && !r.pin0_cfg[CFG_TEMP_BIT];
    next_r.drive = r.pin1_cfg[CFG_DRIVE_BIT];
    next_r.temp = r.pin0_cfg[CFG_TEMP_BIT];
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= BANK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign link.tx_next = r.tx_next;
  assign status_reg_addr = r.addr;
  assign strobe_valid = r.strobe;
  assign strobe_code = r.strobe_code;
  assign multi_write = r.mwr;
  assign multi_write_addr = r.addr;
  assign multi_write_data = r.mwr_data;
  assign general_output_pin0 = r.p0;
  assign general_output_pin0_oe = r.p0_oe;
  assign general_output_pin1 = r.p1;
  assign general_output_pin1_oe = r.p1_oe;
  assign pin_drive_strength = r.drive;
  assign temp_sensor_enable = r.temp;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_burst_addr_step: assert property (link.byte_done && link.cs_active && !link.cs_start &&
      r.phase == PH_DATA && r.burst && in_cfg(r.addr)
      |=> r.addr == $past(r.addr) + ADDR_STEP && r.phase == PH_DATA)
    else $error("burst config access did not step address");
  a_strobe_upper: assert property (strobe_valid |-> !in_cfg(strobe_code) &&
      strobe_code < ADDR_MULTI_FIRST && r.phase == PH_HEADER)
    else $error("strobe outside upper strobe range");
  a_single_ends: assert property (link.byte_done && link.cs_active && !link.cs_start &&
      r.phase == PH_DATA && !r.burst |=> r.phase == PH_HEADER)
    else $error("single access did not return to header");
  a_zero_read: assert property (r.fetch && r.phase == PH_DATA && r.rw && in_cfg(r.addr) &&
      r.addr != ADDR_PIN1_CFG && r.addr != ADDR_PIN0_CFG |=> r.tx_next == 8'h00)
    else $error("unimplemented register read nonzero");
  a_status_header: assert property (r.phase == PH_HEADER ##1 r.phase == PH_HEADER
      |-> r.tx_next == $past(chip_status_byte))
    else $error("status byte not returned in header");
  a_pin1_write: assert property (link.byte_done && link.cs_active && !link.cs_start &&
      r.phase == PH_DATA && !r.rw && r.addr == ADDR_PIN1_CFG
      |=> ##1 pin_drive_strength == $past(link.rx_byte[CFG_DRIVE_BIT], 2))
    else $error("drive strength did not follow pin1 write");
  a_pin1_hiz: assert property (r.pin1_cfg[CFG_SEL_MSB:0] == SEL_HIGH_Z &&
      $stable(r.pin1_cfg) |=> !general_output_pin1_oe)
    else $error("pin1 driven while high-z selected");
  a_pin0_invert: assert property ($stable(r.pin0_cfg) && $stable(internal_signals) &&
      r.pin0_cfg[CFG_SEL_MSB:0] != SEL_XOSC_DIV ##1 $stable(r.pin0_cfg) &&
      $stable(internal_signals)
      |-> general_output_pin0 == (internal_signals[r.pin0_cfg[CFG_SEL_MSB:0]] ^
      r.pin0_cfg[CFG_INV_BIT]))
    else $error("pin0 level not select then invert");
  a_temp_release: assert property (r.pin0_cfg[CFG_TEMP_BIT] |=> temp_sensor_enable &&
      !general_output_pin0_oe)
    else $error("temperature sensor enable not applied");
  a_xosc_half: assert property ($rose(r.xclk_div) |-> ##96 $fell(r.xclk_div))
    else $error("divided crystal half period wrong");

  c_strobe: cover property (strobe_valid);
  c_pin_write: cover property (link.byte_done && r.phase == PH_DATA && !r.rw);
  c_burst_read: cover property (r.fetch && r.phase == PH_DATA && r.rw && r.burst);
  c_multi_write: cover property (multi_write);

endmodule : spi_pin_config_top

/* dv/spi_host_model.sv */
// host side model: drives the serial link in mode 0, msb first
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk_sys,
  input wire logic spi_miso,
  output logic spi_csn,
  output logic spi_sclk,
  output logic spi_mosi
);
  localparam int HALF = 5; // sclk half period in clk_sys cycles, above the minimum of 4
  logic [7:0] rx_shift; // bits gathered from miso
  // idle link: deselected, clock low and still
  initial begin
    spi_csn = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    rx_shift = 8'h00;
  end
  // wait some system clock edges
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_clk
  // select low, then settle before the first sclk rise
  task automatic frame_open();
    @(posedge clk_sys);
    spi_csn <= 1'b0;
    wait_clk(HALF + 1);
  endtask : frame_open
  // select high after a hold, mosi released
  task automatic frame_close();
    wait_clk(HALF);
    spi_csn <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line must not keep the last bit
    wait_clk(HALF + 1);
  endtask : frame_close
  // one byte each way, data changed on the fall, miso taken on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      wait_clk(HALF);
      spi_sclk <= 1'b1;
      rx_shift <= {rx_shift[6:0], spi_miso};
      wait_clk(HALF);
      spi_sclk <= 1'b0;
    end
    rx = rx_shift;
  endtask : xfer
endmodule : spi_host_model

/* dv/test_spi_pin_config_top.sv */
// self-checking bench for the serial pin configuration bank
`timescale 1ns/100ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module test_spi_pin_config_top
  import spi_map_pkg::*;
;
  // ********************************************************
  // signals and instances
  // ********************************************************
  localparam logic [7:0] STATUS = 8'h5A; // fixed chip status byte
  localparam logic [63:0] SIGS = 64'hF0F0_F0F0_F0F0_F0AA; // selectable signal pattern
  logic clk_sys, rstn, spi_csn, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
  logic [7:0] chip_status_byte, status_reg_data, multi_write_data, rx, v;
  logic [63:0] internal_signals;
  logic [5:0] status_reg_addr, strobe_code, multi_write_addr, last_strobe;
  logic strobe_valid, multi_write, pin_drive_strength, temp_sensor_enable;
  logic general_output_pin0, general_output_pin0_oe, general_output_pin1, general_output_pin1_oe;
  int fail_count = 0, comparisons = 0, cyc = 0, strobe_hits = 0, multi_hits = 0, n;
  typedef struct {logic [7:0] cfg; logic pin; logic oe; logic drive;} row_s;
  row_s rows [7] = '{'{8'hC5, 1'b0, 1'b1, 1'b1}, '{8'h05, 1'b1, 1'b1, 1'b0},
    '{8'h41, 1'b0, 1'b1, 1'b0}, '{8'h00, 1'b0, 1'b1, 1'b0}, '{8'h44, 1'b1, 1'b1, 1'b0},
    '{8'h2E, 1'b0, 1'b0, 1'b0}, '{8'hEE, 1'b0, 1'b0, 1'b1}};
  spi_pin_config_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .spi_csn(spi_csn),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .chip_status_byte(chip_status_byte), .internal_signals(internal_signals),
    .status_reg_addr(status_reg_addr), .status_reg_data(status_reg_data),
    .strobe_valid(strobe_valid), .strobe_code(strobe_code), .multi_write(multi_write),
    .multi_write_addr(multi_write_addr), .multi_write_data(multi_write_data),
    .general_output_pin0(general_output_pin0), .general_output_pin0_oe(general_output_pin0_oe),
    .general_output_pin1(general_output_pin1), .general_output_pin1_oe(general_output_pin1_oe),
    .pin_drive_strength(pin_drive_strength), .temp_sensor_enable(temp_sensor_enable));
  spi_host_model u_host (.clk_sys(clk_sys), .spi_miso(spi_miso), .spi_csn(spi_csn),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));
  // ********************************************************
  // clock, status model, monitors, timeout
  // ********************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // status registers answer at once with a code built from the address
  assign status_reg_data = {2'b10, status_reg_addr};
  // count strobe and multi-byte pulses, cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (strobe_valid === 1'b1) begin
      strobe_hits++;
      last_strobe <= strobe_code;
    end
    if (multi_write === 1'b1) multi_hits++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  // ********************************************************
  // tasks
  // ********************************************************
  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // header byte, status returned on it
  task automatic hdr(input logic [7:0] h);
    u_host.xfer(h, rx);
    `CHK("header status", STATUS, rx)
  endtask : hdr
  // single register write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.frame_open();
    hdr(HDR_WRITE_SINGLE | {2'b00, a});
    u_host.xfer(d, rx);
    `CHK("write status", STATUS, rx)
    u_host.frame_close();
  endtask : wr
  // single read with a given header
  task automatic rd(input logic [7:0] h, output logic [7:0] d);
    u_host.frame_open();
    hdr(h);
    u_host.xfer(8'h00, d);
    u_host.frame_close();
  endtask : rd
  // cycles until pin0 changes level
  task automatic wait_change(output int c);
    logic p;
    p = general_output_pin0;
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (general_output_pin0 === p && c < 400);
  endtask : wait_change
  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    rstn <= 1'b0;
    chip_status_byte <= STATUS;
    internal_signals <= SIGS;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK("drive reset", 1'b0, pin_drive_strength)
    `CHK("temp reset", 1'b0, temp_sensor_enable)
    `CHK("pin1 oe reset", 1'b0, general_output_pin1_oe)
    `CHK("pin0 oe reset", 1'b1, general_output_pin0_oe)
    `CHK("miso oe reset", 1'b0, spi_miso_oe)
    wait_change(n);
    wait_change(n);
    `CHK("pin0 half period", XOSC_DIV / 2, n)
    rd(HDR_READ_SINGLE | 8'h01, v);
    `CHK("pin1 cfg reset", PIN1_CFG_RESET, v)
    rd(HDR_READ_SINGLE | 8'h02, v);
    `CHK("pin0 cfg reset", PIN0_CFG_RESET, v)
    // table: pin1 settings and their effect on the pin
    foreach (rows[i]) begin
      wr(ADDR_PIN1_CFG, rows[i].cfg);
      if (rows[i].oe) `CHK("pin1 level", rows[i].pin, general_output_pin1)
      `CHK("pin1 oe", rows[i].oe, general_output_pin1_oe)
      `CHK("drive", rows[i].drive, pin_drive_strength)
      rd(HDR_READ_SINGLE | 8'h01, v);
      `CHK("pin1 readback", rows[i].cfg, v)
    end
    // pin0 invert and select
    wr(ADDR_PIN0_CFG, 8'h43);
    `CHK("pin0 inverted", 1'b0, general_output_pin0)
    wr(ADDR_PIN0_CFG, 8'h03);
    `CHK("pin0 plain", 1'b1, general_output_pin0)
    // burst write runs past the pins into an absent register
    u_host.frame_open();
    hdr(HDR_WRITE_BURST | 8'h01);
    u_host.xfer(8'h07, rx);
    u_host.xfer(8'h08, rx);
    u_host.xfer(8'h12, rx);
    `CHK("burst write status", STATUS, rx)
    u_host.frame_close();
    `CHK("pin0 select 8", 1'b0, general_output_pin0)
    u_host.frame_open();
    hdr(HDR_READ_BURST | 8'h01);
    u_host.xfer(8'h00, v);
    `CHK("burst read 1", 8'h07, v)
    u_host.xfer(8'h00, v);
    `CHK("burst read 2", 8'h08, v)
    u_host.xfer(8'h00, v);
    `CHK("absent reg", 8'h00, v)
    u_host.frame_close();
    // temperature sensor with all other bits zero, then pin0 high-z
    wr(ADDR_PIN0_CFG, 8'h80);
    `CHK("temp on", 1'b1, temp_sensor_enable)
    `CHK("pin0 analog", 1'b0, general_output_pin0_oe)
    wr(ADDR_PIN0_CFG, {2'b00, SEL_HIGH_Z});
    `CHK("pin0 high-z", 1'b0, general_output_pin0_oe)
    // two strobes back to back in one frame, write and plain read
    u_host.frame_open();
    `CHK("miso oe selected", 1'b1, spi_miso_oe)
    hdr(8'h36);
    hdr(8'hBD);
    u_host.frame_close();
    `CHK("miso oe released", 1'b0, spi_miso_oe)
    `CHK("strobe count", 2, strobe_hits)
    `CHK("strobe code", 6'h3D, last_strobe)
    rd(HDR_READ_BURST | 8'h35, v);
    `CHK("status reg", 8'hB5, v)
    `CHK("no strobe on status", 2, strobe_hits)
    // burst write to a multi-byte slot keeps its address
    u_host.frame_open();
    hdr(HDR_WRITE_BURST | {2'b00, ADDR_MULTI_FIRST});
    u_host.xfer(8'h11, rx);
    u_host.xfer(8'h22, rx);
    u_host.frame_close();
    `CHK("multi count", 2, multi_hits)
    `CHK("multi addr", ADDR_MULTI_FIRST, multi_write_addr)
    `CHK("multi data", 8'h22, multi_write_data)
    // second reset in mid-run restores the pin1 setting
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(HDR_READ_SINGLE | 8'h01, v);
    `CHK("pin1 cfg rereset", PIN1_CFG_RESET, v)
    final_report();
  end
endmodule : test_spi_pin_config_top
